//--- pkg/ict_pkg.sv
package ict_pkg;

  // ==========================================================================
  // instruction classes
  // ==========================================================================
  typedef enum logic [4:0] {
    ICT_OP_FIELD_TEST          = 5'h00,
    ICT_OP_FIELD_CHANGE        = 5'h01,
    ICT_OP_FIELD_CLEAR         = 5'h02,
    ICT_OP_FIELD_SET           = 5'h03,
    ICT_OP_FIELD_EXTRACT_S     = 5'h04,
    ICT_OP_FIELD_EXTRACT_U     = 5'h05,
    ICT_OP_FIELD_INSERT        = 5'h06,
    ICT_OP_FIELD_FIRST_ONE     = 5'h07,
    ICT_OP_BRANCH_TAKEN        = 5'h08,
    ICT_OP_BRANCH_B_NOT_TAKEN  = 5'h09,
    ICT_OP_BRANCH_W_NOT_TAKEN  = 5'h0a,
    ICT_OP_BRANCH_L_NOT_TAKEN  = 5'h0b,
    ICT_OP_LOOP_FALSE_LIVE     = 5'h0c,
    ICT_OP_LOOP_FALSE_EXPIRED  = 5'h0d,
    ICT_OP_LOOP_TRUE           = 5'h0e,
    ICT_OP_MODULE_CALL_T0      = 5'h0f,
    ICT_OP_MODULE_CALL_T1_A    = 5'h10,
    ICT_OP_MODULE_CALL_T1_B    = 5'h11,
    ICT_OP_MODULE_CALL_T1_COPY = 5'h12,
    ICT_OP_SWAP_OK             = 5'h13,
    ICT_OP_SWAP_FAIL           = 5'h14,
    ICT_OP_SWAP2_OK            = 5'h15,
    ICT_OP_SWAP2_FAIL          = 5'h16,
    ICT_OP_BOUNDS_PAIR_CHECK   = 5'h17,
    ICT_OP_JUMP_UNCONDITIONAL  = 5'h18,
    ICT_OP_JUMP_SUBROUTINE     = 5'h19
  } ict_op_e;

  typedef enum logic [1:0] {
    ICT_CASE_BEST  = 2'h0,
    ICT_CASE_CACHE = 2'h1,
    ICT_CASE_WORST = 2'h2
  } ict_case_e;

  typedef enum logic [1:0] {
    ICT_FORM_REG  = 2'h0,
    ICT_FORM_MEM4 = 2'h1,
    ICT_FORM_MEM5 = 2'h2
  } ict_form_e;

  typedef enum logic [1:0] {
    ICT_ST_IDLE = 2'h0,
    ICT_ST_RUN  = 2'h1,
    ICT_ST_DONE = 2'h2
  } ict_state_e;

  // ==========================================================================
  // constants
  // ==========================================================================
  localparam logic [4:0]  ICT_OP_LAST        = 5'h19;
  localparam logic [4:0]  ICT_FIELD_OPS      = 5'h08;
  localparam logic [5:0]  ICT_BRANCH_ROW_ADD = 6'h10;
  localparam int          ICT_ROWS           = 42;
  localparam logic [6:0]  ICT_WORD_BITS      = 7'h20;
  localparam logic [5:0]  ICT_WIDTH_FULL     = 6'h20;
  localparam logic [11:0] ICT_COPY_CLK_PER_N = 12'h006;
  localparam logic [11:0] ICT_CLK_RESET      = 12'h000;
  localparam logic [7:0]  ICT_BUS_RESET      = 8'h00;
  localparam logic [31:0] ICT_ACC_RESET      = 32'h0000_0000;

  // ==========================================================================
  // timing table: each entry is {clocks[19:12], reads, prefetches, writes}
  // rows: field op * 3 + form for field ops, then op + 16 for the rest
  // ==========================================================================
  localparam logic [19:0] ICT_TABLE [ICT_ROWS][3] = '{
    '{20'h03000, 20'h06000, 20'h07010}, '{20'h0b100, 20'h0b100, 20'h0c110}, '{20'h0f200, 20'h0f200, 20'h10210},
    '{20'h09000, 20'h0c000, 20'h0c010}, '{20'h10101, 20'h10101, 20'h10111}, '{20'h18202, 20'h18202, 20'h18212},
    '{20'h09000, 20'h0c000, 20'h0c010}, '{20'h10101, 20'h10101, 20'h10111}, '{20'h18202, 20'h18202, 20'h18212},
    '{20'h09000, 20'h0c000, 20'h0c010}, '{20'h10101, 20'h10101, 20'h10111}, '{20'h18202, 20'h18202, 20'h18212},
    '{20'h05000, 20'h08000, 20'h08010}, '{20'h0d100, 20'h0d100, 20'h0d110}, '{20'h12200, 20'h12200, 20'h12210},
    '{20'h05000, 20'h08000, 20'h08010}, '{20'h0d100, 20'h0d100, 20'h0d110}, '{20'h12200, 20'h12200, 20'h12210},
    '{20'h07000, 20'h0a000, 20'h0a010}, '{20'h0e101, 20'h0e101, 20'h0f111}, '{20'h14202, 20'h14202, 20'h15212},
    '{20'h0f000, 20'h12000, 20'h12010}, '{20'h18100, 20'h18100, 20'h18110}, '{20'h20200, 20'h20200, 20'h20210},
    '{20'h03000, 20'h06000, 20'h09020},
    '{20'h01000, 20'h04000, 20'h05010},
    '{20'h03000, 20'h06000, 20'h07010},
    '{20'h03000, 20'h06000, 20'h09020},
    '{20'h03000, 20'h06000, 20'h09020},
    '{20'h07000, 20'h0a000, 20'h0a030},
    '{20'h03000, 20'h06000, 20'h07010},
    '{20'h1c206, 20'h1e206, 20'h24226},
    '{20'h30508, 20'h32508, 20'h38528},
    '{20'h37608, 20'h39608, 20'h40628},
    '{20'h3f708, 20'h41708, 20'h47728},
    '{20'h0f101, 20'h0f101, 20'h10111},
    '{20'h0c100, 20'h0c100, 20'h0d110},
    '{20'h17202, 20'h19202, 20'h1c222},
    '{20'h13200, 20'h16200, 20'h19220},
    '{20'h10200, 20'h12200, 20'h12210},
    '{20'h01000, 20'h04000, 20'h07020},
    '{20'h03001, 20'h05001, 20'h0b021}
  };

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic [7:0] clk;
    logic [3:0] rd;
    logic [3:0] pf;
    logic [3:0] wr;
  } ict_phase_s;

  typedef struct packed {
    ict_op_e    op;
    logic       field_in_reg;
    logic [2:0] field_offset;
    logic [5:0] field_width;
    logic       cache_hit;
    logic       prefetch_overlap;
    logic [7:0] stack_words;
    ict_phase_s phase;
  } ict_req_s;

  typedef struct packed {
    logic [11:0] clk;
    logic [7:0]  rd;
    logic [7:0]  pf;
    logic [7:0]  wr;
    logic        err;
  } ict_result_s;

endpackage

//--- design/ict_lookup.sv
// ============================================================================
// base count lookup
// ============================================================================
module ict_lookup (
  input  wire ict_pkg::ict_op_e   op,
  input  wire ict_pkg::ict_form_e form,
  input  wire ict_pkg::ict_case_e sel,
  output logic [19:0]             base
);

  logic [5:0] row;
  logic [1:0] col;

  // field ops fan out by form, every other class has one row
  always_comb begin
    if (op < ict_pkg::ICT_FIELD_OPS) begin
      row = 6'({1'b0, op} * 6'h03 + {4'h0, form});
    end else begin
      row = {1'b0, op} + ict_pkg::ICT_BRANCH_ROW_ADD;
    end
    col = sel;
    if (row < 6'(ict_pkg::ICT_ROWS) && col != 2'h3) begin
      base = ict_pkg::ICT_TABLE[row][col];
    end else begin
      base = 20'h00000;
    end
  end

endmodule

//--- design/ict_timing_model.sv
// ============================================================================
// instruction cycle timing model
// ============================================================================
// Operation
// RULE1 - totals already include all counted bus cycles
// RULE2 - five-byte field takes two operand cycles
// RULE3 - memory field and swap add address phase; code adds none for ICT_OP_SWAP2_OK and ICT_OP_SWAP2_FAIL
// RULE4 - expired loop: 7/10/10 clocks, three prefetches
// RULE5 - live loop: 3/6/9 clocks, two prefetches
// RULE6 - stack copy call: 63+6n, 7+n reads
// RULE7 - branches and loops add no address phase
// RULE8 - jumps add target address computation phase
// RULE9 - module call and bounds check add fetch
// RULE10 - case picked from cache hit and overlap
module ict_timing_model (
  input  wire                  core_clk,
  input  wire                  rst_n,
  input  wire                  req_valid,
  output logic                 req_ready,
  input  wire ict_pkg::ict_req_s req,
  output logic                 res_valid,
  output ict_pkg::ict_result_s res,
  output logic                 busy,
  input  wire                  stats_clear,
  output logic [31:0]          stat_instr,
  output logic [31:0]          stat_clk
);

  // ==========================================================================
  // case and form selection
  // ==========================================================================
  ict_pkg::ict_case_e sel;
  ict_pkg::ict_form_e form;
  logic [6:0]         span_bits;
  logic [6:0]         width_bits;
  logic [19:0]        base;
  logic               is_field;
  logic               add_phase;
  logic               legal_op;

  // overlap only pays off while the words come from the on-chip cache
  always_comb begin
    if (!req.cache_hit) begin
      sel = ict_pkg::ICT_CASE_WORST; // RULE10
    end else if (req.prefetch_overlap) begin
      sel = ict_pkg::ICT_CASE_BEST; // RULE10
    end else begin
      sel = ict_pkg::ICT_CASE_CACHE; // RULE10
    end
  end

  // a zero width field means a full 32-bit field
  always_comb begin
    width_bits = (req.field_width == 6'h00) ? 7'(ict_pkg::ICT_WIDTH_FULL) : {1'b0, req.field_width};
    span_bits  = {4'h0, req.field_offset} + width_bits;
    is_field   = req.op < ict_pkg::ICT_FIELD_OPS;
    legal_op   = req.op <= ict_pkg::ICT_OP_LAST;
    if (!is_field || req.field_in_reg) begin
      form = ict_pkg::ICT_FORM_REG;
    end else if (span_bits > ict_pkg::ICT_WORD_BITS) begin
      form = ict_pkg::ICT_FORM_MEM5; // RULE2
    end else begin
      form = ict_pkg::ICT_FORM_MEM4; // RULE2
    end
  end

  ict_lookup u_lookup (
    .op   (req.op),
    .form (form),
    .sel  (sel),
    .base (base)
  );

  // ==========================================================================
  // phase addition
  // ==========================================================================
  // branch and loop rows are complete on their own, no phase for any size
  always_comb begin
    unique case (req.op)
      ict_pkg::ICT_OP_SWAP_OK,
      ict_pkg::ICT_OP_SWAP_FAIL:          add_phase = 1'b1; // RULE3
      ict_pkg::ICT_OP_JUMP_UNCONDITIONAL,
      ict_pkg::ICT_OP_JUMP_SUBROUTINE:    add_phase = 1'b1; // RULE8
      ict_pkg::ICT_OP_MODULE_CALL_T0,
      ict_pkg::ICT_OP_MODULE_CALL_T1_A,
      ict_pkg::ICT_OP_MODULE_CALL_T1_B,
      ict_pkg::ICT_OP_MODULE_CALL_T1_COPY,
      ict_pkg::ICT_OP_BOUNDS_PAIR_CHECK:  add_phase = 1'b1; // RULE9
      ict_pkg::ICT_OP_BRANCH_TAKEN,
      ict_pkg::ICT_OP_BRANCH_B_NOT_TAKEN,
      ict_pkg::ICT_OP_BRANCH_W_NOT_TAKEN,
      ict_pkg::ICT_OP_BRANCH_L_NOT_TAKEN,
      ict_pkg::ICT_OP_LOOP_FALSE_LIVE,
      ict_pkg::ICT_OP_LOOP_FALSE_EXPIRED,
      ict_pkg::ICT_OP_LOOP_TRUE:          add_phase = 1'b0; // RULE7
      default:                            add_phase = is_field && !req.field_in_reg; // RULE3
    endcase
  end

  // ==========================================================================
  // total computation
  // ==========================================================================
  ict_pkg::ict_result_s calc;
  logic [11:0]          copy_clk;
  logic [7:0]           copy_words;

  // the table clock figure already holds its bus cycles; they are reported, never added to it
  always_comb begin
    copy_words = (req.op == ict_pkg::ICT_OP_MODULE_CALL_T1_COPY) ? req.stack_words : 8'h00; // RULE6
    copy_clk   = 12'({4'h0, copy_words} * ict_pkg::ICT_COPY_CLK_PER_N); // RULE6
    calc.clk   = {4'h0, base[19:12]} + copy_clk; // RULE1
    calc.rd    = {4'h0, base[11:8]} + copy_words; // RULE6
    calc.pf    = {4'h0, base[7:4]}; // RULE4 RULE5
    calc.wr    = {4'h0, base[3:0]} + copy_words; // RULE6
    calc.err   = !legal_op;
    if (add_phase) begin
      calc.clk = calc.clk + {4'h0, req.phase.clk};
      calc.rd  = calc.rd + {4'h0, req.phase.rd};
      calc.pf  = calc.pf + {4'h0, req.phase.pf};
      calc.wr  = calc.wr + {4'h0, req.phase.wr};
    end
    // an unknown class still occupies one clock so the handshake completes
    if (!legal_op) begin
      calc.clk = 12'h001;
      calc.rd  = ict_pkg::ICT_BUS_RESET;
      calc.pf  = ict_pkg::ICT_BUS_RESET;
      calc.wr  = ict_pkg::ICT_BUS_RESET;
    end
  end

  // ==========================================================================
  // sequencer: hold the model busy for the instruction's clock total
  // ==========================================================================
  ict_pkg::ict_state_e  state_q, state_d;
  logic [11:0]          cnt_q, cnt_d;
  ict_pkg::ict_result_s res_q, res_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    res_d   = res_q;
    unique case (state_q)
      ict_pkg::ICT_ST_IDLE: begin
        if (req_valid) begin
          res_d   = calc;
          cnt_d   = (calc.clk == ict_pkg::ICT_CLK_RESET) ? 12'h001 : calc.clk;
          state_d = ict_pkg::ICT_ST_RUN;
        end
      end
      ict_pkg::ICT_ST_RUN: begin
        if (cnt_q == 12'h001) begin
          state_d = ict_pkg::ICT_ST_DONE;
        end else begin
          cnt_d = cnt_q - 12'h001;
        end
      end
      ict_pkg::ICT_ST_DONE: begin
        state_d = ict_pkg::ICT_ST_IDLE;
      end
      default: begin
        state_d = ict_pkg::ICT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ict_pkg::ICT_ST_IDLE;
      cnt_q   <= ict_pkg::ICT_CLK_RESET;
      res_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      res_q   <= res_d;
    end
  end

  // ==========================================================================
  // statistics
  // ==========================================================================
  logic [31:0] instr_q, instr_d;
  logic [31:0] clk_q, clk_d;

  // a completion in the clearing cycle is kept, so clear loses to the count
  always_comb begin
    instr_d = stats_clear ? ict_pkg::ICT_ACC_RESET : instr_q;
    clk_d   = stats_clear ? ict_pkg::ICT_ACC_RESET : clk_q;
    if (state_q == ict_pkg::ICT_ST_DONE) begin
      instr_d = instr_d + 32'h0000_0001;
      clk_d   = clk_d + {20'h00000, res_q.clk};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      instr_q <= ict_pkg::ICT_ACC_RESET;
      clk_q   <= ict_pkg::ICT_ACC_RESET;
    end else begin
      instr_q <= instr_d;
      clk_q   <= clk_d;
    end
  end

  // handshake outputs decoded from state, data straight from flip-flops
  assign req_ready  = state_q == ict_pkg::ICT_ST_IDLE;
  assign busy       = state_q == ict_pkg::ICT_ST_RUN;
  assign res_valid  = state_q == ict_pkg::ICT_ST_DONE;
  assign res        = res_q;
  assign stat_instr = instr_q;
  assign stat_clk   = clk_q;

endmodule

//--- sim/ict_timing_model_properties.sv
// ==========================================================================
// port-level checks of the timing model
// ==========================================================================
module ict_timing_model_chk (
  input wire                       core_clk,
  input wire                       rst_n,
  input wire                       req_valid,
  input wire                       req_ready,
  input wire ict_pkg::ict_req_s    req,
  input wire                       res_valid,
  input wire ict_pkg::ict_result_s res,
  input wire                       busy,
  input wire                       stats_clear,
  input wire [31:0]                stat_instr,
  input wire [31:0]                stat_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        acc;
  logic        best;
  logic [11:0] run_q;
  assign acc  = req_valid && req_ready;
  assign best = req.cache_hit && req.prefetch_overlap;
  // busy cycles since the accept; bus cycles must sit inside this total, not after it
  always_ff @(posedge core_clk) begin
    if (!rst_n || acc) run_q <= 12'h000;
    else if (busy) run_q <= run_q + 12'h001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_total; res_valid |-> run_q == res.clk; endproperty
  a_total: assert property (p_total) else $error("busy length differs from total");
  property p_pulse; res_valid |=> !res_valid && req_ready; endproperty
  a_pulse: assert property (p_pulse) else $error("result pulse too long");
  property p_take; acc |=> busy && !req_ready; endproperty
  a_take: assert property (p_take) else $error("accept did not start a run");
  property p_expired; acc && req.op == ict_pkg::ICT_OP_LOOP_FALSE_EXPIRED |=>
    res.clk == ($past(best) ? 12'h007 : 12'h00a) && res.pf == ($past(req.cache_hit) ? 8'h00 : 8'h03); endproperty
  a_expired: assert property (p_expired) else $error("expired loop count wrong");
  property p_live; acc && req.op == ict_pkg::ICT_OP_LOOP_FALSE_LIVE |=> res.pf == ($past(req.cache_hit) ? 8'h00 : 8'h02)
    && res.clk == ($past(best) ? 12'h003 : ($past(req.cache_hit) ? 12'h006 : 12'h009)); endproperty
  a_live: assert property (p_live) else $error("live loop count wrong");
  property p_copy; acc && req.op == ict_pkg::ICT_OP_MODULE_CALL_T1_COPY && best |=>
    res.clk == 12'h03f + 12'h006 * 12'($past(req.stack_words)) + 12'($past(req.phase.clk))
    && res.rd == 8'h07 + $past(req.stack_words) + 8'($past(req.phase.rd)); endproperty
  a_copy: assert property (p_copy) else $error("stack copy call count wrong");
  property p_jump; acc && req.op == ict_pkg::ICT_OP_JUMP_UNCONDITIONAL && best |=>
    res.clk == 12'h001 + 12'($past(req.phase.clk)); endproperty
  a_jump: assert property (p_jump) else $error("jump count wrong");
  property p_bounds; acc && req.op == ict_pkg::ICT_OP_BOUNDS_PAIR_CHECK && best |=>
    res.clk == 12'h010 + 12'($past(req.phase.clk)); endproperty
  a_bounds: assert property (p_bounds) else $error("bounds check count wrong");
  property p_field5; acc && req.op == ict_pkg::ICT_OP_FIELD_TEST && !req.field_in_reg && (7'(req.field_offset)
    + ((req.field_width == 6'h00) ? 7'h20 : 7'(req.field_width))) > 7'h20 |=>
    res.rd == 8'h02 + 8'($past(req.phase.rd)); endproperty
  a_field5: assert property (p_field5) else $error("five byte field reads wrong");
  property p_stat; res_valid |=> stat_instr == ($past(stats_clear) ? 32'h1 : $past(stat_instr) + 32'h1); endproperty
  a_stat: assert property (p_stat) else $error("completion count wrong");
  property p_statclk; res_valid |=> stat_clk == ($past(stats_clear) ? 32'h0 : $past(stat_clk))
    + 32'($past(res.clk)); endproperty
  a_statclk: assert property (p_statclk) else $error("clock sum wrong");
endmodule

bind ict_timing_model ict_timing_model_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .res_valid(res_valid), .res(res), .busy(busy), .stats_clear(stats_clear),
  .stat_instr(stat_instr), .stat_clk(stat_clk));

//--- sim/ict_seq_model.sv
// ==========================================================================
// sequencer model: offers one request and holds it until taken
// ==========================================================================
module ict_seq_model (
  input  wire                    core_clk,
  input  wire                    rst_n,
  input  wire                    issue,
  input  wire ict_pkg::ict_req_s req_in,
  input  wire                    req_ready,
  output logic                   req_valid,
  output ict_pkg::ict_req_s      req
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle request lines toggle so a stale value can never pass for a fresh one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_valid <= 1'b0;
      req       <= ~req_in;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
    end else if (issue) begin
      req_valid <= 1'b1;
      req       <= req_in;
    end else if (!req_valid) begin
      req <= ~req;
    end
  end
endmodule

//--- sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk, rst_n, issue, req_ready, req_valid, res_valid, busy, stats_clear;
  logic [31:0]          stat_instr, stat_clk;
  ict_pkg::ict_req_s    req_in, req;
  ict_pkg::ict_result_s res;
  ict_pkg::ict_phase_s  ph = '{8'h04, 4'h1, 4'h1, 4'h0};
  int                   errors = 0, compares = 0, cyc = 0;

  ict_seq_model u_seq (.core_clk(core_clk), .rst_n(rst_n), .issue(issue), .req_in(req_in),
    .req_ready(req_ready), .req_valid(req_valid), .req(req));
  ict_timing_model DUT (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .res_valid(res_valid), .res(res), .busy(busy), .stats_clear(stats_clear),
    .stat_instr(stat_instr), .stat_clk(stat_clk));

  // ========================================================================
  // clock and hang guard
  // ========================================================================
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one request through the sequencer model, then judge the result
  // plain int arguments keep the call sites free of width mismatches; fields are cut to size here
  task automatic run(input int op, input int in_reg, input int off, input int wid,
                     input int hit, input int ovl, input int n, input int ec,
                     input int er, input int ep, input int ew);
    int i;
    int nb;
    nb     = 0;
    req_in = '{ict_pkg::ict_op_e'(5'(op)), 1'(in_reg), 3'(off), 6'(wid), 1'(hit), 1'(ovl), 8'(n), ph};
    issue  = 1'b1;
    @(posedge core_clk);
    #1 issue = 1'b0;
    // count the busy cycles seen between accept and result
    for (i = 0; i < 400 && res_valid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
      if (busy === 1'b1) begin
        nb++;
      end
    end
    check("res_valid", 32'(res_valid), 32'h1);
    check("busy_len", 32'(nb), 32'(ec));
    check("res_clk", 32'(res.clk), 32'(ec));
    check("res_rd", 32'(res.rd), 32'(er));
    check("res_pf", 32'(res.pf), 32'(ep));
    check("res_wr", 32'(res.wr), 32'(ew));
    check("res_err", 32'(res.err), 32'(op > ict_pkg::ICT_OP_LAST));
  endtask

  // ========================================================================
  // scenarios
  // ========================================================================
  task automatic t_reset();
    check("ready", 32'(req_ready), 32'h1);
    check("busy", 32'(busy), 32'h0);
    check("res_valid", 32'(res_valid), 32'h0);
    check("res", 32'(|res), 32'h0);
    check("stat_instr", stat_instr, 32'h0);
    check("stat_clk", stat_clk, 32'h0);
  endtask

  task automatic t_field();
    run(ict_pkg::ICT_OP_FIELD_TEST, 1, 3'h0, 6'h00, 1, 1, 0, 12'h003, 0, 0, 0);
    run(ict_pkg::ICT_OP_FIELD_TEST, 0, 3'h1, 6'h00, 0, 0, 0, 12'h014, 3, 2, 0);
    run(ict_pkg::ICT_OP_FIELD_TEST, 0, 3'h0, 6'h00, 1, 0, 0, 12'h00f, 2, 1, 0);
    run(ict_pkg::ICT_OP_FIELD_FIRST_ONE, 0, 3'h7, 6'h1a, 1, 1, 0, 12'h024, 3, 1, 0);
    run(ict_pkg::ICT_OP_FIELD_INSERT, 0, 3'h3, 6'h10, 0, 0, 0, 12'h013, 2, 2, 1);
  endtask

  // every case of both loop-false outcomes (expired and live); the supplied phase must be ignored
  task automatic t_loop();
    logic [11:0] ce[3] = '{12'h007, 12'h00a, 12'h00a};
    logic [11:0] cl[3] = '{12'h003, 12'h006, 12'h009};
    logic [7:0]  pe[3] = '{8'h00, 8'h00, 8'h03};
    logic [7:0]  pl[3] = '{8'h00, 8'h00, 8'h02};
    for (int k = 0; k < 3; k++) begin
      run(ict_pkg::ICT_OP_LOOP_FALSE_EXPIRED, 0, 0, 0, 1'(k < 2), 1'(k == 0), 0, ce[k], 0, pe[k], 0);
      run(ict_pkg::ICT_OP_LOOP_FALSE_LIVE, 0, 0, 0, 1'(k < 2), 1'(k == 0), 0, cl[k], 0, pl[k], 0);
    end
  endtask

  task automatic t_call();
    run(ict_pkg::ICT_OP_MODULE_CALL_T1_COPY, 0, 0, 0, 1, 1, 8'h04, 12'h05b, 8'h0c, 1, 8'h0c);
    run(ict_pkg::ICT_OP_MODULE_CALL_T1_COPY, 0, 0, 0, 0, 0, 8'h00, 12'h04b, 8, 3, 8);
    run(ict_pkg::ICT_OP_MODULE_CALL_T0, 0, 0, 0, 1, 0, 0, 12'h022, 3, 1, 6);
  endtask

  task automatic t_jump();
    run(ict_pkg::ICT_OP_JUMP_UNCONDITIONAL, 0, 0, 0, 1, 1, 0, 12'h005, 1, 1, 0);
    run(ict_pkg::ICT_OP_JUMP_SUBROUTINE, 0, 0, 0, 0, 1, 0, 12'h00f, 1, 3, 1);
    run(ict_pkg::ICT_OP_BOUNDS_PAIR_CHECK, 0, 0, 0, 1, 1, 0, 12'h014, 3, 1, 0);
  endtask

  task automatic t_swap();
    run(ict_pkg::ICT_OP_SWAP_OK, 0, 0, 0, 1, 1, 0, 12'h013, 2, 1, 1);
    run(ict_pkg::ICT_OP_SWAP2_FAIL, 0, 0, 0, 0, 0, 0, 12'h019, 2, 2, 0);
    run(5'h1f, 0, 0, 0, 1, 1, 0, 12'h001, 0, 0, 0);
  endtask

  // clear lands in the completion cycle of the one-clock illegal request: the count wins
  task automatic t_stats();
    stats_clear = 1'b1;
    @(posedge core_clk);
    #1;
    check("stat_keep", stat_instr, 32'h1);
    check("stat_keep_clk", stat_clk, 32'h1);
    @(posedge core_clk);
    #1 stats_clear = 1'b0;
    check("stat_clr", stat_instr, 32'h0);
    check("stat_clr_clk", stat_clk, 32'h0);
    run(ict_pkg::ICT_OP_JUMP_UNCONDITIONAL, 0, 0, 0, 1, 1, 0, 12'h005, 1, 1, 0);
    run(ict_pkg::ICT_OP_LOOP_FALSE_LIVE, 0, 0, 0, 1, 1, 0, 12'h003, 0, 0, 0);
    @(posedge core_clk);
    #1;
    check("stat_instr", stat_instr, 32'h2);
    check("stat_clk", stat_clk, 32'h8);
  endtask

  initial begin
    rst_n       = 1'b0;
    issue       = 1'b0;
    stats_clear = 1'b0;
    req_in      = '0;
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_field();
    t_loop();
    t_call();
    t_jump();
    t_swap();
    t_stats();
    results();
  end
endmodule
